// [verilog/pfj_top.sv]
// PWM frequency-jitter control: registers, approach-mode stepping and dead-time pacing.
// Assumes a classic Wishbone master and a PWM core giving triggers, section levels and target status.
//
// Contract
// - Trigger-count shift 10 adds in T2, subtracts in T3; 11 reverse; else hold.
// - Trigger count saturates at 111 rising and 000 falling.
// - Trigger count stops changing once PWM reached the approach target.
// - Step shift 10 adds in T2, subtracts in T3; 11 reverse; else hold.
// - Approach step saturates at 111 rising and 000 falling.
// - Approach step stays constant once the approach target is reached.
// - Dead-time zero enable bit gates dead-time zero modification.
// - Dead-time one enable bit gates dead-time one modification.
// - Dead-time one shift 10 adds in T2, subtracts in T3; 11 reverse.
// - Dead-time one step saturates at 111 and 000.
// - Dead-time one interval code selects 4, 8, 12 or 16 triggers.
// - Dead-time one change magnitude equals code plus one.
// - Count-mode step count equals code plus one.
// - Count-mode direction bit: 0 increases, 1 decreases.
// - Count-mode register bit 7 always reads zero.
// - Approach trigger count code plus one triggers make each step.
// - Approach step gives period change 2*(code+1), duty change code+1.
// - Adjustment count gives 1 to 8 adjustments of all four values.
// - Count-mode change gives period 2*(code+1), duty code+1.
`default_nettype none
module pfj_top (
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        PWM_TRIG_I,
    input  wire logic        SECTION_T2_I,
    input  wire logic        SECTION_T3_I,
    input  wire logic        TARGET_REACHED_I,
    input  wire logic        APPROACH_START_I,
    output logic             APPROACH_ACTIVE_O,
    output logic      [3:0]  STEP_TRIGGERS_O,
    output logic      [4:0]  PERIOD_DELTA_O,
    output logic      [3:0]  DUTY_DELTA_O,
    output logic      [3:0]  DT0_DELTA_O,
    output logic      [3:0]  DT1_DELTA_O,
    output logic             DT0_MODIFY_O,
    output logic             DT1_MODIFY_O,
    output logic      [3:0]  COUNT_STEPS_O,
    output logic             COUNT_DIR_O,
    output logic      [4:0]  COUNT_PERIOD_DELTA_O,
    output logic      [3:0]  COUNT_DUTY_DELTA_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // Saturating T2/T3 adjustment of a three-bit field.
    function automatic logic [2:0] adjust_field(
        input logic [2:0] value,
        input logic [1:0] shift,
        input logic       in_t2,
        input logic       in_t3
    );
        logic up;
        logic down;
        up   = ((shift == pfj_pkg::SHIFT_UP_T2) && in_t2) || ((shift == pfj_pkg::SHIFT_DOWN_T2) && in_t3);
        down = ((shift == pfj_pkg::SHIFT_UP_T2) && in_t3) || ((shift == pfj_pkg::SHIFT_DOWN_T2) && in_t2);
        if (up && value != pfj_pkg::FIELD_MAX) begin
            adjust_field = 3'(value + 3'h1);
        end else if (down && value != pfj_pkg::FIELD_MIN) begin
            adjust_field = 3'(value - 3'h1);
        end else begin
            adjust_field = value;
        end
    endfunction

    // Code plus one, widened to four bits.
    function automatic logic [3:0] plus_one(input logic [2:0] code);
        plus_one = 4'({1'b0, code} + 4'h1);
    endfunction

    logic [7:0]  approach_step_ctrl;
    logic [7:0]  approach_adjust_ctrl;
    logic [7:0]  approach_dead_time_zero_ctrl;
    logic [7:0]  approach_dead_time_one_ctrl;
    logic [7:0]  count_mode_step_ctrl;
    logic        ack;
    logic [31:0] rdata;

    pfj_pkg::pfj_state_type state;
    logic [2:0]  work_count;
    logic [2:0]  work_step;
    logic [2:0]  work_dt0;
    logic [2:0]  work_dt1;
    logic [3:0]  remain;
    logic [2:0]  trig_cnt;
    logic [3:0]  dt0_tcnt;
    logic [3:0]  dt1_tcnt;
    logic        dt0_pulse;
    logic        dt1_pulse;

    // Field views of the control registers.
    wire logic [2:0] approach_trigger_count        = approach_step_ctrl[pfj_pkg::POS_TRIGGER_COUNT +: 3];
    wire logic [2:0] approach_step_size            = approach_step_ctrl[pfj_pkg::POS_STEP_SIZE +: 3];
    wire logic [2:0] adjustment_count              = approach_adjust_ctrl[pfj_pkg::POS_ADJUST_COUNT +: 3];
    wire logic [1:0] approach_trigger_count_shift  = approach_adjust_ctrl[pfj_pkg::POS_COUNT_SHIFT +: 2];
    wire logic [1:0] approach_step_shift           = approach_adjust_ctrl[pfj_pkg::POS_STEP_SHIFT +: 2];
    wire logic       approach_dead_time_zero_enable = approach_dead_time_zero_ctrl[pfj_pkg::POS_DT_ENABLE];
    wire logic [1:0] dead_time_zero_step_shift     = approach_dead_time_zero_ctrl[pfj_pkg::POS_DT_SHIFT +: 2];
    wire logic [1:0] dead_time_zero_interval       = approach_dead_time_zero_ctrl[pfj_pkg::POS_DT_INTERVAL +: 2];
    wire logic [2:0] dead_time_zero_step           = approach_dead_time_zero_ctrl[pfj_pkg::POS_DT_STEP +: 3];
    wire logic       approach_dead_time_one_enable = approach_dead_time_one_ctrl[pfj_pkg::POS_DT_ENABLE];
    wire logic [1:0] dead_time_one_step_shift      = approach_dead_time_one_ctrl[pfj_pkg::POS_DT_SHIFT +: 2];
    wire logic [1:0] dead_time_one_interval        = approach_dead_time_one_ctrl[pfj_pkg::POS_DT_INTERVAL +: 2];
    wire logic [2:0] dead_time_one_step            = approach_dead_time_one_ctrl[pfj_pkg::POS_DT_STEP +: 3];
    wire logic [2:0] count_mode_step_count         = count_mode_step_ctrl[pfj_pkg::POS_CM_STEPS +: 3];
    wire logic       count_mode_direction          = count_mode_step_ctrl[pfj_pkg::POS_CM_DIR];
    wire logic [2:0] count_mode_change_size        = count_mode_step_ctrl[pfj_pkg::POS_CM_SIZE +: 3];

    // Bus decode.
    wire logic bus_req   = WB_CYC_I && WB_STB_I;
    wire logic bus_write = bus_req && WB_WE_I && ack && WB_SEL_I[0];
    wire logic hit_step  = WB_ADR_I == pfj_pkg::ADDR_APPROACH_STEP_CTRL;
    wire logic hit_adj   = WB_ADR_I == pfj_pkg::ADDR_APPROACH_ADJUST_CTRL;
    wire logic hit_dt0   = WB_ADR_I == pfj_pkg::ADDR_APPROACH_DT0_CTRL;
    wire logic hit_dt1   = WB_ADR_I == pfj_pkg::ADDR_APPROACH_DT1_CTRL;
    wire logic hit_cm    = WB_ADR_I == pfj_pkg::ADDR_COUNT_STEP_CTRL;
    wire logic hit_stat  = WB_ADR_I == pfj_pkg::ADDR_APPROACH_STATUS;

    wire logic [7:0] wbyte = WB_DAT_I[7:0];
    wire logic running     = state == pfj_pkg::ST_RUN;
    wire logic frozen      = TARGET_REACHED_I;

    wire logic [31:0] status_word =
        (32'({1'b0, work_count}) << pfj_pkg::POS_ST_COUNT) |
        (32'({1'b0, work_step}) << pfj_pkg::POS_ST_STEP) |
        (32'({1'b0, work_dt0}) << pfj_pkg::POS_ST_DT0) |
        (32'({1'b0, work_dt1}) << pfj_pkg::POS_ST_DT1) |
        (32'(remain) << pfj_pkg::POS_ST_REMAIN) |
        (32'(running) << pfj_pkg::POS_ST_ACTIVE) |
        (32'(frozen) << pfj_pkg::POS_ST_FROZEN);

    logic [31:0] next_rdata;
    always_comb begin
        if (hit_step) begin
            next_rdata = {24'h000000, approach_step_ctrl};
        end else if (hit_adj) begin
            next_rdata = {24'h000000, approach_adjust_ctrl};
        end else if (hit_dt0) begin
            next_rdata = {24'h000000, approach_dead_time_zero_ctrl};
        end else if (hit_dt1) begin
            next_rdata = {24'h000000, approach_dead_time_one_ctrl};
        end else if (hit_cm) begin
            next_rdata = {24'h000000, count_mode_step_ctrl};
        end else if (hit_stat) begin
            next_rdata = status_word;
        end else begin
            next_rdata = 32'h00000000;
        end
    end

    // Approach stepping: a step ends when its trigger count has passed.
    wire logic step_end   = running && PWM_TRIG_I && (trig_cnt == work_count);
    wire logic do_adjust  = step_end && !frozen;
    wire logic last_adj   = remain == 4'h1;

    // Dead-time pacing: limit is four times the code plus one, minus one.
    wire logic [3:0] dt0_limit = {dead_time_zero_interval, 2'b11};
    wire logic [3:0] dt1_limit = {dead_time_one_interval, 2'b11};
    wire logic dt0_tick = running && PWM_TRIG_I && approach_dead_time_zero_enable;
    wire logic dt1_tick = running && PWM_TRIG_I && approach_dead_time_one_enable;
    wire logic dt0_wrap = dt0_tick && (dt0_tcnt == dt0_limit);
    wire logic dt1_wrap = dt1_tick && (dt1_tcnt == dt1_limit);

    // Wishbone slave: ack one cycle after the request, writes commit on the ack edge.
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            ack   <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack   <= bus_req && !ack;
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            approach_step_ctrl           <= pfj_pkg::RESET_CTRL;
            approach_adjust_ctrl         <= pfj_pkg::RESET_CTRL;
            approach_dead_time_zero_ctrl <= pfj_pkg::RESET_CTRL;
            approach_dead_time_one_ctrl  <= pfj_pkg::RESET_CTRL;
            count_mode_step_ctrl         <= pfj_pkg::RESET_CTRL;
        end else if (bus_write) begin
            if (hit_step) begin
                approach_step_ctrl <= wbyte & pfj_pkg::MASK_APPROACH_STEP_CTRL;
            end
            if (hit_adj) begin
                approach_adjust_ctrl <= wbyte & pfj_pkg::MASK_APPROACH_ADJUST_CTRL;
            end
            if (hit_dt0) begin
                approach_dead_time_zero_ctrl <= wbyte & pfj_pkg::MASK_DT_CTRL;
            end
            if (hit_dt1) begin
                approach_dead_time_one_ctrl <= wbyte & pfj_pkg::MASK_DT_CTRL;
            end
            if (hit_cm) begin
                count_mode_step_ctrl <= wbyte & pfj_pkg::MASK_COUNT_STEP_CTRL;
            end
        end
    end

    // Approach sequencer.
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            state      <= pfj_pkg::ST_IDLE;
            work_count <= 3'h0;
            work_step  <= 3'h0;
            work_dt0   <= 3'h0;
            work_dt1   <= 3'h0;
            remain     <= 4'h0;
            trig_cnt   <= 3'h0;
        end else if (APPROACH_START_I) begin
            state      <= pfj_pkg::ST_RUN;
            work_count <= approach_trigger_count;
            work_step  <= approach_step_size;
            work_dt0   <= dead_time_zero_step;
            work_dt1   <= dead_time_one_step;
            remain     <= plus_one(adjustment_count);
            trig_cnt   <= 3'h0;
        end else begin
            case (state)
                pfj_pkg::ST_IDLE: begin
                    trig_cnt <= 3'h0;
                end
                pfj_pkg::ST_RUN: begin
                    if (step_end) begin
                        trig_cnt <= 3'h0;
                        remain   <= 4'(remain - 4'h1);
                        if (last_adj) begin
                            state <= pfj_pkg::ST_IDLE;
                        end
                    end else if (PWM_TRIG_I) begin
                        trig_cnt <= 3'(trig_cnt + 3'h1);
                    end
                    if (do_adjust) begin
                        work_count <= adjust_field(work_count, approach_trigger_count_shift,
                                                   SECTION_T2_I, SECTION_T3_I);
                        work_step  <= adjust_field(work_step, approach_step_shift,
                                                   SECTION_T2_I, SECTION_T3_I);
                        work_dt0   <= adjust_field(work_dt0, dead_time_zero_step_shift,
                                                   SECTION_T2_I, SECTION_T3_I);
                        work_dt1   <= adjust_field(work_dt1, dead_time_one_step_shift,
                                                   SECTION_T2_I, SECTION_T3_I);
                    end
                end
                default: begin
                    state <= pfj_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Dead-time interval counters.
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I || APPROACH_START_I) begin
            dt0_tcnt  <= 4'h0;
            dt1_tcnt  <= 4'h0;
            dt0_pulse <= 1'b0;
            dt1_pulse <= 1'b0;
        end else begin
            dt0_pulse <= dt0_wrap;
            dt1_pulse <= dt1_wrap;
            if (dt0_wrap) begin
                dt0_tcnt <= 4'h0;
            end else if (dt0_tick) begin
                dt0_tcnt <= 4'(dt0_tcnt + 4'h1);
            end
            if (dt1_wrap) begin
                dt1_tcnt <= 4'h0;
            end else if (dt1_tick) begin
                dt1_tcnt <= 4'(dt1_tcnt + 4'h1);
            end
        end
    end

    // Registered data outputs.
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            STEP_TRIGGERS_O      <= 4'h0;
            PERIOD_DELTA_O       <= 5'h00;
            DUTY_DELTA_O         <= 4'h0;
            DT0_DELTA_O          <= 4'h0;
            DT1_DELTA_O          <= 4'h0;
            COUNT_STEPS_O        <= 4'h0;
            COUNT_DIR_O          <= 1'b0;
            COUNT_PERIOD_DELTA_O <= 5'h00;
            COUNT_DUTY_DELTA_O   <= 4'h0;
        end else begin
            STEP_TRIGGERS_O      <= plus_one(work_count);
            PERIOD_DELTA_O       <= {plus_one(work_step), 1'b0};
            DUTY_DELTA_O         <= plus_one(work_step);
            DT0_DELTA_O          <= plus_one(work_dt0);
            DT1_DELTA_O          <= plus_one(work_dt1);
            COUNT_STEPS_O        <= plus_one(count_mode_step_count);
            COUNT_DIR_O          <= count_mode_direction;
            COUNT_PERIOD_DELTA_O <= {plus_one(count_mode_change_size), 1'b0};
            COUNT_DUTY_DELTA_O   <= plus_one(count_mode_change_size);
        end
    end

    assign WB_ACK_O          = ack;
    assign WB_DAT_O          = rdata;
    assign APPROACH_ACTIVE_O = running;
    assign DT0_MODIFY_O      = dt0_pulse;
    assign DT1_MODIFY_O      = dt1_pulse;

endmodule // pfj_top
`default_nettype wire

// [verilog/pfj_pkg.sv]
// Constants for the PWM frequency-jitter control block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`default_nettype none
package pfj_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDR_APPROACH_STEP_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_APPROACH_ADJUST_CTRL = 8'h04;
    localparam logic [7:0] ADDR_APPROACH_DT0_CTRL    = 8'h08;
    localparam logic [7:0] ADDR_APPROACH_DT1_CTRL    = 8'h0c;
    localparam logic [7:0] ADDR_COUNT_STEP_CTRL      = 8'h10;
    localparam logic [7:0] ADDR_APPROACH_STATUS      = 8'h14;

    localparam logic [7:0] RESET_CTRL = 8'h00;

    // Field masks of the writable bits of each register.
    localparam logic [7:0] MASK_APPROACH_STEP_CTRL   = 8'h77;
    localparam logic [7:0] MASK_APPROACH_ADJUST_CTRL = 8'h7f;
    localparam logic [7:0] MASK_DT_CTRL              = 8'hff;
    localparam logic [7:0] MASK_COUNT_STEP_CTRL      = 8'h7f;

    // Field positions, given as the low bit of each field.
    localparam int POS_TRIGGER_COUNT = 4;
    localparam int POS_STEP_SIZE     = 0;
    localparam int POS_ADJUST_COUNT  = 4;
    localparam int POS_COUNT_SHIFT   = 2;
    localparam int POS_STEP_SHIFT    = 0;
    localparam int POS_DT_ENABLE     = 7;
    localparam int POS_DT_SHIFT      = 5;
    localparam int POS_DT_INTERVAL   = 3;
    localparam int POS_DT_STEP       = 0;
    localparam int POS_CM_STEPS      = 4;
    localparam int POS_CM_DIR        = 3;
    localparam int POS_CM_SIZE       = 0;

    // Status layout.
    localparam int POS_ST_COUNT  = 0;
    localparam int POS_ST_STEP   = 4;
    localparam int POS_ST_DT0    = 8;
    localparam int POS_ST_DT1    = 12;
    localparam int POS_ST_REMAIN = 16;
    localparam int POS_ST_ACTIVE = 24;
    localparam int POS_ST_FROZEN = 25;

    // Change codes for the T2/T3 shift fields.
    localparam logic [1:0] SHIFT_UP_T2   = 2'b10;
    localparam logic [1:0] SHIFT_DOWN_T2 = 2'b11;

    localparam logic [2:0] FIELD_MAX = 3'h7;
    localparam logic [2:0] FIELD_MIN = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } pfj_state_type;
endpackage : pfj_pkg
`default_nettype wire

// [bench/pfj_properties.sv]
// Concurrent checks on the ports of the PWM frequency-jitter control block.
// Assumes one clock, REF_CLK_I, with the synchronous active-low reset RESET_N_I.
`default_nettype none
module pfj_checker (
    input wire logic        REF_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        PWM_TRIG_I,
    input wire logic        TARGET_REACHED_I,
    input wire logic        APPROACH_START_I,
    input wire logic        APPROACH_ACTIVE_O,
    input wire logic [3:0]  STEP_TRIGGERS_O,
    input wire logic [4:0]  PERIOD_DELTA_O,
    input wire logic [3:0]  DUTY_DELTA_O,
    input wire logic        DT0_MODIFY_O,
    input wire logic        DT1_MODIFY_O,
    input wire logic [3:0]  COUNT_STEPS_O,
    input wire logic        COUNT_DIR_O,
    input wire logic [4:0]  COUNT_PERIOD_DELTA_O,
    input wire logic [3:0]  COUNT_DUTY_DELTA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire cm_read = WB_ACK_O && !WB_WE_I && WB_ADR_I == pfj_pkg::ADDR_COUNT_STEP_CTRL;
    ack_follows_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not acknowledged one cycle later");
    ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    cm_top_zero_a: assert property (cm_read |-> WB_DAT_O[7] == 1'b0)
        else $error("count-mode top bit read as one");
    cm_fields_a: assert property (cm_read |-> COUNT_STEPS_O == {1'b0, WB_DAT_O[6:4]} + 4'h1
        && COUNT_DIR_O == WB_DAT_O[3] && COUNT_DUTY_DELTA_O == {1'b0, WB_DAT_O[2:0]} + 4'h1
        && COUNT_PERIOD_DELTA_O == {COUNT_DUTY_DELTA_O, 1'b0})
        else $error("count-mode outputs disagree with register");
    start_runs_a: assert property (APPROACH_START_I |=> APPROACH_ACTIVE_O)
        else $error("start did not begin a run");
    freeze_hold_a: assert property ((TARGET_REACHED_I && !APPROACH_START_I) [*2]
        |=> $stable(STEP_TRIGGERS_O) && $stable(DUTY_DELTA_O))
        else $error("approach values moved while target reached");
    delta_pair_a: assert property ($past(RESET_N_I) |-> PERIOD_DELTA_O == {DUTY_DELTA_O, 1'b0}
        && STEP_TRIGGERS_O inside {[4'h1:4'h8]})
        else $error("approach delta outputs inconsistent");
    dt_cause_a: assert property (DT0_MODIFY_O || DT1_MODIFY_O |-> $past(PWM_TRIG_I)
        && $past(APPROACH_ACTIVE_O))
        else $error("dead-time pulse without a trigger in a run");
    cover property (APPROACH_START_I);
    cover property (DT1_MODIFY_O);
    cover property ($fell(APPROACH_ACTIVE_O));
    cover property (cm_read);
endmodule // pfj_checker
bind pfj_top pfj_checker u_chk (.*);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking testbench for the PWM frequency-jitter control block.
// Assumes the pfj_top ports and the register map of pfj_pkg.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic        trig = 1'b0;
    logic        t2 = 1'b0;
    logic        t3 = 1'b0;
    logic        tgt = 1'b0;
    logic        start = 1'b0;
    logic [31:0] rdat;
    logic        ack, active, dt0_mod, dt1_mod, cm_dir;
    logic [3:0]  step_trig, duty_d, dt0_d, dt1_d, cm_steps, cm_duty;
    logic [4:0]  per_d, cm_per;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [7:0]  adr_tab [6] = '{pfj_pkg::ADDR_APPROACH_STEP_CTRL, pfj_pkg::ADDR_APPROACH_ADJUST_CTRL,
        pfj_pkg::ADDR_APPROACH_DT0_CTRL, pfj_pkg::ADDR_APPROACH_DT1_CTRL, pfj_pkg::ADDR_COUNT_STEP_CTRL, 8'h18};
    logic [7:0]  msk_tab [6] = '{8'h77, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'h00};

    always #10ns clk = ~clk;

    pfj_top uut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PWM_TRIG_I(trig), .SECTION_T2_I(t2), .SECTION_T3_I(t3), .TARGET_REACHED_I(tgt),
        .APPROACH_START_I(start), .APPROACH_ACTIVE_O(active), .STEP_TRIGGERS_O(step_trig),
        .PERIOD_DELTA_O(per_d), .DUTY_DELTA_O(duty_d), .DT0_DELTA_O(dt0_d), .DT1_DELTA_O(dt1_d),
        .DT0_MODIFY_O(dt0_mod), .DT1_MODIFY_O(dt1_mod), .COUNT_STEPS_O(cm_steps), .COUNT_DIR_O(cm_dir),
        .COUNT_PERIOD_DELTA_O(cm_per), .COUNT_DUTY_DELTA_O(cm_duty));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; waits for the acknowledge with no limit of its own.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic pulse_start();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic pulse_trig(input int n);
        repeat (n) begin
            @(posedge clk);
            trig <= 1'b1;
            @(posedge clk);
            trig <= 1'b0;
            #1;
        end
    endtask

    function automatic logic [2:0] exp_adj(input logic [2:0] v, input logic [1:0] c, input logic sec2);
        if (c[1] == 1'b0) return v;
        if ((c[0] == 1'b0) == sec2) return (v == 3'h7) ? v : v + 3'h1;
        return (v == 3'h0) ? v : v - 3'h1;
    endfunction

    task automatic t_regs();
        logic [31:0] d;
        check({step_trig, duty_d, dt0_d, dt1_d, cm_steps, cm_duty}, 24'h111111);
        foreach (adr_tab[i]) begin
            wb(1'b0, adr_tab[i], 8'h00, d);
            check(d, 32'h0);
            wb(1'b1, adr_tab[i], 8'hff, d);
            wb(1'b0, adr_tab[i], 8'h00, d);
            check(d, {24'h0, msk_tab[i]});
        end
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, adr_tab[4], {1'b1, c[2:0], c[0], c[2:0]}, d);
            wb(1'b0, adr_tab[4], 8'h00, d);
            check({cm_steps, cm_dir, cm_per, cm_duty}, {4'(c + 1), c[0], 5'(2 * c + 2), 4'(c + 1)});
        end
    endtask

    task automatic t_shift();
        logic [31:0] d;
        logic [2:0]  e;
        for (int k = 0; k < 8; k++) begin
            e = exp_adj(3'h3, k[1:0], k[2]);
            t2 <= k[2];
            t3 <= !k[2];
            wb(1'b1, adr_tab[0], 8'h33, d);
            wb(1'b1, adr_tab[1], {4'h0, k[1:0], k[1:0]}, d);
            wb(1'b1, adr_tab[2], {1'b0, k[1:0], 5'h03}, d);
            wb(1'b1, adr_tab[3], {1'b0, k[1:0], 5'h03}, d);
            pulse_start();
            pulse_trig(4);
            check(active, 1'b0);
            wb(1'b0, pfj_pkg::ADDR_APPROACH_STATUS, 8'h00, d);
            check(d[14:0], {e, 1'b0, e, 1'b0, e, 1'b0, e});
            check({step_trig, duty_d, dt0_d, dt1_d}, {4{1'b0, e + 3'h1}});
        end
    endtask

    task automatic t_limits();
        logic [31:0] d;
        t2 <= 1'b1;
        t3 <= 1'b0;
        wb(1'b1, adr_tab[0], 8'h70, d);
        wb(1'b1, adr_tab[1], 8'h1b, d);
        wb(1'b1, adr_tab[2], 8'h47, d);
        wb(1'b1, adr_tab[3], 8'h60, d);
        pulse_start();
        pulse_trig(8);
        check(active, 1'b1);
        pulse_trig(8);
        check(active, 1'b0);
        wb(1'b0, pfj_pkg::ADDR_APPROACH_STATUS, 8'h00, d);
        check(d[14:0], 15'h0707);
        tgt <= 1'b1;
        wb(1'b1, adr_tab[0], 8'h33, d);
        wb(1'b1, adr_tab[1], 8'h0a, d);
        pulse_start();
        pulse_trig(4);
        wb(1'b0, pfj_pkg::ADDR_APPROACH_STATUS, 8'h00, d);
        check({d[25], d[6:0]}, {1'b1, 7'h33});
        tgt <= 1'b0;
    endtask

    task automatic t_pace();
        logic [31:0] d;
        logic        hit;
        int          n;
        wb(1'b1, adr_tab[0], 8'h70, d);
        wb(1'b1, adr_tab[1], 8'h70, d);
        wb(1'b1, adr_tab[2], 8'h00, d);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, adr_tab[3], {3'b100, k[1:0], 3'h5}, d);
            pulse_start();
            n = 0;
            hit = 1'b0;
            while (n < 20) begin
                pulse_trig(1);
                n++;
                hit = hit | dt0_mod;
                if (dt1_mod === 1'b1) break;
            end
            check(n, 4 * (k + 1));
            check(hit, 1'b0);
            check(dt1_d, 4'h6);
        end
        wb(1'b1, adr_tab[2], 8'h80, d);
        pulse_start();
        pulse_trig(3);
        check(dt0_mod, 1'b0);
        pulse_trig(1);
        check(dt0_mod, 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_shift();
        t_limits();
        t_pace();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
